// ---- bench/osc_model.sv ----
// Purpose: Main oscillator start-up model on the clock controller side.
// Assumes: main_osc_run enables the oscillator; ready is a level.
// Notes: Ready drops on the first pclk edge after the oscillator is stopped.
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
  parameter int start_cycles = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic main_osc_run,
  output logic main_osc_ready
);
  int cnt_q;
  // Start-up count restarts whenever the oscillator is gated off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= start_cycles;
    end else if (!main_osc_run) begin
      cnt_q <= 0;
    end else if (cnt_q < start_cycles) begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign main_osc_ready = (cnt_q == start_cycles);
endmodule // osc_model
`default_nettype wire

// ---- bench/power_state_controller_asserts.sv ----
// Purpose: Port-level checks on sleep entry, wake timing and gates.
// Assumes: Single pclk domain, presetn asynchronous active low.
// Notes: Brown-out low time is counted in helper logic.
`timescale 1ns/1ps
`default_nettype none
module power_state_controller_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sleep_instr,
  input wire logic debug_break,
  input wire logic [1:0] brownout_active_cfg,
  input wire logic brownout_ready,
  input wire logic main_osc_ready,
  input wire sleep_ctrl_pkg::clock_gates_t clock_gates,
  input wire logic cpu_halted,
  input wire logic irq_take,
  input wire logic osc_restart
);
  import sleep_ctrl_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] bl_q;
  logic [3:0] bl_d;
  // Cycles that brownout_ready has been low, saturating
  assign bl_d = brownout_ready ? 4'h0 : (bl_q == 4'hf ? bl_q : bl_q + 4'h1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bl_q <= 4'h0;
    else bl_q <= bl_d;
  end
  sleep_entry_a: assert property (
    !cpu_halted && !sleep_instr |=> !cpu_halted)
    else $error("halt without sleep");
  cpu_clock_a: assert property (
    cpu_halted && $past(cpu_halted) |-> !clock_gates.cpu_clk_run)
    else $error("cpu clock runs asleep");
  watchdog_clock_a: assert property (
    clock_gates.watchdog_clock_run && clock_gates.periodic_wake_timer_run)
    else $error("watchdog or periodic clock stopped");
  break_wake_a: assert property (
    $rose(debug_break) && cpu_halted && main_osc_ready && brownout_ready
    |-> ##[1:20] !cpu_halted) else $error("break did not wake");
  wake_count_a: assert property (
    $fell(osc_restart) && brownout_active_cfg != 2'h3
    |-> cpu_halted [*6] ##1 !cpu_halted) else $error("wake count not six");
  take_after_a: assert property (
    irq_take |-> !cpu_halted && $past(cpu_halted))
    else $error("irq_take not after wake");
  take_pulse_a: assert property (
    irq_take |=> !irq_take) else $error("irq_take longer than one cycle");
  brownout_hold_a: assert property (
    cpu_halted && brownout_active_cfg == 2'h3 && bl_q > 4'h5 |=> cpu_halted)
    else $error("woke before brown-out ready");
endmodule // power_state_controller_asserts
bind power_state_controller power_state_controller_asserts i_asserts (
  .pclk, .presetn, .sleep_instr, .debug_break, .brownout_active_cfg,
  .brownout_ready, .main_osc_ready, .clock_gates, .cpu_halted, .irq_take,
  .osc_restart);
`default_nettype wire

// ---- bench/power_state_controller_tb.sv ----
// Purpose: Directed tests of registers, sleep entry and wake paths.
// Assumes: APB answers with zero wait states; irq lines are levels.
// Notes: Idle wake cycle count is checked exactly, brown-out wake below 20.
`timescale 1ns/1ps
`default_nettype none
module power_state_controller_tb;
  import sleep_ctrl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_instr = 1'b0;
  logic global_irq_en = 1'b1, debug_break = 1'b0, brownout_ready = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] brownout_active_cfg = 2'h0;
  logic pready, pslverr, er, cpu_halted, irq_take, osc_restart, main_osc_ready;
  logic os, tk;
  wake_irq_t irq_pending = 8'h00, irq_enable = 8'hff;
  clock_gates_t clock_gates;
  int num_errors = 0, compares = 0, n;
  always #10 pclk = ~pclk;
  power_state_controller i_power_state_controller (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .sleep_instr, .global_irq_en, .irq_pending, .irq_enable, .debug_break,
    .brownout_active_cfg, .brownout_ready, .main_osc_ready, .clock_gates,
    .cpu_halted, .irq_take, .osc_restart);
  osc_model i_osc_model (.pclk, .presetn,
    .main_osc_run(clock_gates.main_osc_run), .main_osc_ready);
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic go_sleep(input logic [1:0] m, input logic en);
    apb(1'b1, 8'h00, {29'h0, m, en});
    @(posedge pclk); sleep_instr <= 1'b1;
    @(posedge pclk); sleep_instr <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  // Raise requests and count cycles until the CPU runs again
  task automatic wake(input logic [7:0] b);
    irq_pending <= b; n = 0; os = 1'b0;
    tk = 1'b0;
    while (cpu_halted === 1'b1 && n < 200) begin
      @(posedge pclk); n++;
      if (osc_restart === 1'b1) os = 1'b1;
      if (irq_take === 1'b1) tk = 1'b1;
    end
    irq_pending <= 8'h00;
    chk("woke", 32'(cpu_halted), 32'h0);
  endtask
  task automatic stays(input logic [7:0] b);
    irq_pending <= b;
    repeat (25) @(posedge pclk);
    chk("stays_asleep", 32'(cpu_halted), 32'h1);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0); chk("ctrl_reset", rd, 32'h0);
    apb(1'b1, 8'h00, 32'hff); apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_rw", rd, 32'h7);
    apb(1'b0, 8'h0c, 32'h0); chk("unmapped", 32'(er), 32'h1);
    repeat (3) @(posedge pclk);
    chk("no_sleep_on_write", 32'(cpu_halted), 32'h0);
    go_sleep(mode_reserved, 1'b1);
    chk("reserved", 32'(cpu_halted), 32'h0);
    go_sleep(mode_idle, 1'b0);
    chk("disabled", 32'(cpu_halted), 32'h0);
    $display("test entry done");
    go_sleep(mode_idle, 1'b1);
    chk("idle_halt", 32'(cpu_halted), 32'h1);
    chk("idle_per", 32'(clock_gates.peripheral_clock_run), 32'h1);
    chk("idle_cpu", 32'(clock_gates.cpu_clk_run), 32'h0);
    // One cycle to take the request, six to wake, one to see it
    wake(8'h01); chk("idle_wake", n, 32'(wake_cycles) + 32'h2);
    chk("idle_take", 32'(tk), 32'h1);
    chk("idle_no_osc", 32'(os), 32'h0);
    go_sleep(mode_standby, 1'b1);
    chk("sb_per", 32'(clock_gates.peripheral_clock_run), 32'h0);
    chk("sb_osc", 32'(clock_gates.main_osc_run), 32'h0);
    stays(8'h01);
    wake(8'h10); chk("sb_osc_wait", 32'(os), 32'h1);
    apb(1'b1, 8'h04, 32'h9); go_sleep(mode_standby, 1'b1);
    chk("sb_rtc", 32'(clock_gates.rtc_run), 32'h1);
    wake(8'h02); chk("sb_osc_run", 32'(os), 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    $display("test idle standby done");
    go_sleep(power_down_code, 1'b1);
    chk("pd_rtc", 32'(clock_gates.rtc_run), 32'h0);
    stays(8'h10); irq_enable <= 8'h00; stays(8'h80);
    irq_enable <= 8'hff; global_irq_en <= 1'b0; stays(8'h80);
    global_irq_en <= 1'b1;
    wake(8'h80); chk("pd_pin_osc", 32'(os), 32'h1);
    go_sleep(power_down_code, 1'b1); wake(8'h40);
    chk("pd_addr", 32'(cpu_halted), 32'h0);
    go_sleep(power_down_code, 1'b1); debug_break <= 1'b1; wake(8'h00);
    chk("break_wake", 32'(cpu_halted), 32'h0);
    chk("break_take", 32'(tk), 32'h0);
    debug_break <= 1'b0;
    // Break from idle, where the oscillator never stops
    go_sleep(mode_idle, 1'b1); debug_break <= 1'b1; wake(8'h00);
    chk("idle_break", 32'(cpu_halted), 32'h0);
    debug_break <= 1'b0;
    $display("test power down done");
    brownout_active_cfg <= 2'h3; brownout_ready <= 1'b0;
    go_sleep(mode_idle, 1'b1); stays(8'h01);
    brownout_ready <= 1'b1; wake(8'h01);
    chk("bod_wake", 32'(n < 20), 32'h1);
    brownout_active_cfg <= 2'h0;
    go_sleep(mode_idle, 1'b1); presetn <= 1'b0;
    @(posedge pclk); presetn <= 1'b1;
    @(posedge pclk); chk("reset_wake", 32'(cpu_halted), 32'h0);
    apb(1'b0, 8'h00, 32'h0); chk("reset_ctrl", rd, 32'h0);
    $display("test brownout reset done");
    results();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    results();
  end
endmodule // power_state_controller_tb
`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter.
// Assumes: Input is asynchronous to pclk.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_q, s2_q, s3_q, out_q;

  // Shift chain; first stage read only by second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) out_q <= s3_q;
    end
  end
  assign sync_out = out_q;
endmodule // pin_sync
`default_nettype wire

// ---- rtl/power_state_controller.sv ----
// Purpose: Sleep controller with APB registers, wake timing and gates.
// Assumes: CPU pulses sleep_instr for one pclk when it runs sleep.
// Notes: Any reset returns the block to active through presetn.
`timescale 1ns/1ps
`default_nettype none
module power_state_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic global_irq_en,
  input wire sleep_ctrl_pkg::wake_irq_t irq_pending,
  input wire sleep_ctrl_pkg::wake_irq_t irq_enable,
  input wire logic debug_break,
  input wire logic [1:0] brownout_active_cfg,
  input wire logic brownout_ready,
  input wire logic main_osc_ready,
  output sleep_ctrl_pkg::clock_gates_t clock_gates,
  output logic cpu_halted,
  output logic irq_take,
  output logic osc_restart
);
  import sleep_ctrl_pkg::*;

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] wcfg_q, wcfg_d;
  sleep_state_t state_q, state_d;
  sleep_mode_t mode_q, mode_d;
  logic main_off_q, main_off_d;
  logic [3:0] cnt_q, cnt_d;
  logic from_irq_q, from_irq_d;
  logic [31:0] rdata_q;
  clock_gates_t gates_q, gates_d;
  logic irq_take_q;
  logic dbg_sync, brownout_sync, osc_sync;
  logic wake_req;

  // Break and analog readiness come from other domains
  pin_sync u_dbg (
    .pclk(pclk), .presetn(presetn), .async_in(debug_break),
    .sync_out(dbg_sync));
  pin_sync u_brownout (
    .pclk(pclk), .presetn(presetn), .async_in(brownout_ready),
    .sync_out(brownout_sync));
  pin_sync u_osc (
    .pclk(pclk), .presetn(presetn), .async_in(main_osc_ready),
    .sync_out(osc_sync));

  wake_qualifier u_wq (
    .mode(mode_q), .irq_pending(irq_pending), .irq_enable(irq_enable),
    .wake_config(wcfg_q), .wake(wake_req));

  // APB decode: zero-wait slave, error on unmapped address
  wire apb_access = psel & penable;
  wire hit_ctrl = (paddr == sleep_control_off);
  wire hit_wcfg = (paddr == wake_config_off);
  wire hit_stat = (paddr == sleep_status_off);
  wire mapped = hit_ctrl | hit_wcfg | hit_stat;
  wire wr_ctrl = apb_access & pwrite & hit_ctrl & pstrb[0];
  wire wr_wcfg = apb_access & pwrite & hit_wcfg & pstrb[0];
  assign pready = 1'b1;
  assign pslverr = apb_access & ~mapped;
  assign prdata = rdata_q;

  // Mode field and enable bit as seen at the sleep instruction
  wire sleep_mode_t sel_mode =
    sleep_mode_t'(ctrl_q[sleep_mode_msb:sleep_mode_lsb]);
  wire sleep_enable_bit = ctrl_q[sleep_enable_bit_pos];
  wire go_sleep = (state_q == st_active) & sleep_instr
    & sleep_enable_bit & (sel_mode != mode_reserved);
  wire brownout_wait = (brownout_active_cfg == brownout_wait_cfg);
  // Main oscillator held in standby with its own, the ADC or the UART run-in-standby
  wire main_kept_sb = wcfg_q[main_osc_standby_pos]
    | wcfg_q[adc_standby_pos] | wcfg_q[uart_standby_pos];
  wire main_stops = (sel_mode == power_down_code)
    | ((sel_mode == mode_standby) & ~main_kept_sb);
  // Interrupt wake only with global enable set
  wire irq_wake = wake_req & global_irq_en;

  // Register writes; reserved bits read as zero
  always_comb begin
    ctrl_d = ctrl_q;
    wcfg_d = wcfg_q;
    if (wr_ctrl) ctrl_d = {5'h00, pwdata[2:0]};
    if (wr_wcfg) wcfg_d = {1'b0, pwdata[6:0]};
  end

  // Sleep sequencer
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    main_off_d = main_off_q;
    cnt_d = cnt_q;
    from_irq_d = from_irq_q;
    case (state_q)
      st_active: begin
        if (go_sleep) begin
          state_d = st_asleep;
          mode_d = sel_mode;
          main_off_d = main_stops;
        end
      end
      st_asleep: begin
        if (dbg_sync | irq_wake) begin
          from_irq_d = irq_wake & ~dbg_sync;
          cnt_d = 4'h0;
          state_d = main_off_q ? st_wake_osc : st_wake_count;
        end
      end
      st_wake_osc: begin
        if (osc_sync) state_d = st_wake_count;
      end
      st_wake_count: begin
        if (cnt_q != wake_cycles) cnt_d = cnt_q + 4'h1;
        if ((cnt_q == wake_cycles - 4'h1) | (cnt_q == wake_cycles)) begin
          if (!brownout_wait || brownout_sync) begin
            state_d = st_active;
            mode_d = mode_idle;
          end
        end
      end
      default: state_d = st_active;
    endcase
  end

  // Clock gates per mode and run-in-standby settings
  always_comb begin
    gates_d = '0;
    gates_d.watchdog_clock_run = 1'b1;
    gates_d.periodic_wake_timer_run = 1'b1;
    if (state_q == st_active) begin
      gates_d = '1;
    end else if (state_q == st_asleep) begin
      case (mode_q)
        mode_idle: begin
          gates_d.peripheral_clock_run = 1'b1;
          gates_d.rtc_run = 1'b1;
          gates_d.touch_controller_run = 1'b1;
          gates_d.main_osc_run = 1'b1;
          gates_d.rtc_osc_run = 1'b1;
          gates_d.ultra_low_power_osc_run = 1'b1;
        end
        mode_standby: begin
          gates_d.rtc_run = wcfg_q[rtc_standby_pos];
          gates_d.touch_controller_run = wcfg_q[adc_standby_pos];
          gates_d.main_osc_run = ~main_off_q;
          gates_d.rtc_osc_run = wcfg_q[rtc_osc_standby_pos];
          gates_d.ultra_low_power_osc_run = 1'b1;
        end
        power_down_code: begin
          gates_d.ultra_low_power_osc_run =
            wcfg_q[brownout_uses_lp_osc_pos]
            | wcfg_q[watchdog_uses_lp_osc_pos];
          gates_d.rtc_osc_run = gates_d.ultra_low_power_osc_run;
        end
        default: gates_d.ultra_low_power_osc_run = 1'b1;
      endcase
    end else begin
      // Waking: oscillators back, CPU still halted
      gates_d.main_osc_run = 1'b1;
      gates_d.rtc_osc_run = 1'b1;
      gates_d.ultra_low_power_osc_run = 1'b1;
      gates_d.peripheral_clock_run = (state_q == st_wake_count);
    end
    gates_d.cpu_clk_run = (state_q == st_active);
  end

  // State flops; presetn from any reset source ends sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sleep_control_rst;
      wcfg_q <= wake_config_rst;
      state_q <= st_active;
      mode_q <= mode_idle;
      main_off_q <= 1'b0;
      cnt_q <= 4'h0;
      from_irq_q <= 1'b0;
      gates_q <= '1;
      irq_take_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      wcfg_q <= wcfg_d;
      state_q <= state_d;
      mode_q <= mode_d;
      main_off_q <= main_off_d;
      cnt_q <= cnt_d;
      from_irq_q <= from_irq_d;
      gates_q <= gates_d;
      irq_take_q <= (state_q == st_wake_count)
        & (state_d == st_active) & from_irq_q;
    end
  end

  // Read data register, captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      rdata_q <= hit_ctrl ? {24'h000000, ctrl_q} :
                 hit_wcfg ? {24'h000000, wcfg_q} :
                 hit_stat ? {26'h0, main_off_q, from_irq_q, mode_q,
                             state_q} : 32'h0000_0000;
    end
  end

  assign clock_gates = gates_q;
  assign cpu_halted = (state_q != st_active);
  assign irq_take = irq_take_q;
  assign osc_restart = (state_q == st_wake_osc);
endmodule // power_state_controller
`default_nettype wire

// ---- rtl/sleep_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the sleep mode controller.
// Assumes: Register bus is APB with 32-bit data, one word per register.
// Notes: Reset values, offsets, fields and counts live here only.
//
// What this block does
// - Debug break wakes sleeping device unconditionally
// - Sleep only on instruction with enable set
// - Mode field bits 2:1: idle, standby, power-down
// - Idle stops CPU; all interrupts wake
// - Standby units run only with run-in-standby
// - Standby wake sources listed, some need run-in-standby
// - Power down: watchdog, periodic timer; pin/address wake
// - CPU clock stops; peripheral clock only idle
// - Wake takes 6 cycles plus oscillator start-up
// - Idle wake adds no oscillator start-up
// - Standby adds start-up only if oscillator stopped
// - Power down keeps only low-power and RTC osc, if low-power osc used
// - Brown-out config 3 holds wake until ready
// - Interrupt wake runs handler then continues
// - Any reset leaves sleep
package sleep_ctrl_pkg;

  localparam logic [7:0] sleep_control_off = 8'h00;
  localparam logic [7:0] wake_config_off = 8'h04;
  localparam logic [7:0] sleep_status_off = 8'h08;
  localparam logic [7:0] sleep_control_rst = 8'h00;
  localparam logic [7:0] wake_config_rst = 8'h00;
  localparam int sleep_enable_bit_pos = 0;
  localparam int sleep_mode_lsb = 1;
  localparam int sleep_mode_msb = 2;

  // Wake config bits: run-in-standby selections and low-power osc users
  localparam int rtc_standby_pos = 0;
  localparam int adc_standby_pos = 1;
  localparam int uart_standby_pos = 2;
  localparam int main_osc_standby_pos = 3;
  localparam int rtc_osc_standby_pos = 4;
  localparam int brownout_uses_lp_osc_pos = 5;
  localparam int watchdog_uses_lp_osc_pos = 6;

  localparam logic [1:0] brownout_wait_cfg = 2'h3;
  localparam logic [3:0] wake_cycles = 4'h6;

  typedef enum logic [1:0] {
    mode_idle = 2'b00,
    mode_standby = 2'b01,
    power_down_code = 2'b10,
    mode_reserved = 2'b11
  } sleep_mode_t;

  typedef enum logic [1:0] {
    st_active = 2'b00,
    st_asleep = 2'b01,
    st_wake_osc = 2'b10,
    st_wake_count = 2'b11
  } sleep_state_t;

  // Interrupt request lines grouped by wake class
  typedef struct packed {
    logic pin_change;
    logic address_match;
    logic periodic_wake_timer;
    logic capture_timer;
    logic uart_frame_start;
    logic adc_window;
    logic rtc;
    logic other;
  } wake_irq_t;

  // Clock and oscillator gates driven to the clock controller
  typedef struct packed {
    logic cpu_clk_run;
    logic peripheral_clock_run;
    logic rtc_run;
    logic touch_controller_run;
    logic periodic_wake_timer_run;
    logic watchdog_clock_run;
    logic main_osc_run;
    logic rtc_osc_run;
    logic ultra_low_power_osc_run;
  } clock_gates_t;

endpackage

// ---- rtl/wake_qualifier.sv ----
// Purpose: Decide which pending interrupts may wake the selected mode.
// Assumes: Requests and enables are on pclk.
// Notes: Combinational only.
`timescale 1ns/1ps
`default_nettype none
module wake_qualifier (
  input wire sleep_ctrl_pkg::sleep_mode_t mode,
  input wire sleep_ctrl_pkg::wake_irq_t irq_pending,
  input wire sleep_ctrl_pkg::wake_irq_t irq_enable,
  input wire logic [7:0] wake_config,
  output logic wake
);
  import sleep_ctrl_pkg::*;

  wire wake_irq_t live = irq_pending & irq_enable;
  wire rtc_sb = wake_config[rtc_standby_pos];
  wire adc_sb = wake_config[adc_standby_pos];
  wire uart_sb = wake_config[uart_standby_pos];
  wire idle_wake = |live;
  // Standby wake set; UART, ADC and RTC requests gated by their run-in-standby
  wire standby_wake = live.pin_change | live.address_match
    | live.periodic_wake_timer | live.capture_timer
    | (live.uart_frame_start & uart_sb) | (live.adc_window & adc_sb)
    | (live.rtc & rtc_sb);
  wire power_down_wake = live.pin_change | live.address_match;

  // Select by mode; reserved never sleeps so never wakes
  assign wake = (mode == mode_idle) ? idle_wake :
                (mode == mode_standby) ? standby_wake :
                (mode == power_down_code) ? power_down_wake : 1'b0;
endmodule // wake_qualifier
`default_nettype wire
